// [hw/ssac_codec.sv]
// Session setup attribute codec: APB registers, emitter and parser
// Notes on behaviour
// - Max payload counts IP, L2TPv3 header and payload, not Ethernet.
// - Node sends remote max payload with type 7, length 8, M set.
// - Node's remote max payload is its largest receivable layer-3 size.
// - UDP port attribute: type 8, length 8, M set, 16-bit port.
// - Node may send port only with UDP on and a different port wanted.
// - Node never sends the port attribute for a multicast session.
// - Join addresses are 16 bytes each; IPv4 in first four.
// - Node subscribes to the received source and group addresses.
// - Capability attribute: type 13, length 8, M set.
// - Capability flag one means sender supports multicast signaling.
// - Node always sets its capability flag to one.
// - Both sides parse and generate the capability attribute.
`timescale 1ns/1ps
`include "ssac_consts.svh"
module ssac_codec
  import ssac_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID = `SSAC_VENDOR_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_sop,
  input wire logic [31:0] rx_word,
  output logic tx_valid,
  output logic [31:0] tx_word,
  output logic tx_last,
  input wire logic tx_ready,
  output logic join_valid,
  output logic [127:0] join_src,
  output logic [127:0] join_grp
);
  // Register state
  logic udp_en;
  logic mcast_sess;
  logic [15:0] local_mtu_cfg;
  logic [15:0] sess_port;
  logic [15:0] cc_port;
  logic [2:0] pend;
  logic len_err;
  logic peer_cap;
  logic port_supp;
  logic join_seen;
  logic [15:0] peer_mtu;
  logic [15:0] peer_port;

  // APB decode
  wire setup_wait = psel & penable & ~pready;
  wire done = psel & penable & pready;
  wire wr = done & pwrite;
  wire sel_ctrl = (paddr == `SSAC_OFF_CTRL);
  wire sel_mtu = (paddr == `SSAC_OFF_MTU);
  wire sel_ports = (paddr == `SSAC_OFF_PORTS);
  wire sel_stat = (paddr == `SSAC_OFF_STATUS);
  wire sel_pmtu = (paddr == `SSAC_OFF_PEER_MTU);
  wire sel_pport = (paddr == `SSAC_OFF_PEER_PORT);
  wire sel_jsrc = (paddr == `SSAC_OFF_JOIN_SRC);
  wire sel_jgrp = (paddr == `SSAC_OFF_JOIN_GRP);
  wire mapped = sel_ctrl | sel_mtu | sel_ports | sel_stat | sel_pmtu |
    sel_pport | sel_jsrc | sel_jgrp;
  wire wr_ctrl = wr & sel_ctrl;
  wire wr_stat = wr & sel_stat;

  // Emitter interface
  logic gen_load;
  logic [15:0] gen_type;
  logic [15:0] gen_value;
  logic gen_busy;
  wire gen_free = ~gen_busy & ~gen_load;
  // Port only when UDP is on, unicast, and a different port is wanted
  wire port_ok = udp_en & ~mcast_sess & (sess_port != cc_port);
  wire go_mtu = gen_free & pend[0];
  wire go_port = gen_free & ~pend[0] & pend[1];
  wire go_cap = gen_free & ~pend[0] & ~pend[1] & pend[2];
  wire port_drop = go_port & ~port_ok;
  // Capability payload: flag forced to one, rest reserved
  wire [15:0] cap_value = 16'h0001 << `SSAC_CAP_C_BIT;

  // Parser decode
  ssac_rx_state_t rx_state;
  logic [9:0] hdr_len;
  logic [3:0] idx;
  logic joining;
  wire [15:0] rx_type = rx_word[31:16];
  wire is_lmtu = (rx_type == `SSAC_TYPE_LOCAL_MTU);
  wire is_rmtu = (rx_type == `SSAC_TYPE_REMOTE_MTU);
  wire is_port = (rx_type == `SSAC_TYPE_UDP_PORT);
  wire is_join = (rx_type == `SSAC_TYPE_JOIN);
  wire is_cap = (rx_type == `SSAC_TYPE_CAP);
  wire known = is_lmtu | is_rmtu | is_port | is_join | is_cap;
  wire [9:0] exp_len = is_join ? `SSAC_LEN_JOIN : `SSAC_LEN_SHORT;
  wire type_word = rx_valid & ~rx_sop & (rx_state == SSAC_RX_BODY) &
    (idx == 4'h1);
  wire bad_len = type_word & known & (hdr_len != exp_len);
  wire good = type_word & known & ~bad_len;
  wire join_word = rx_valid & ~rx_sop & joining;
  wire join_end = join_word & (idx == `SSAC_JOIN_LAST_IDX);
  wire stat_clr_err = wr_stat & pwdata[`SSAC_ST_LEN_ERR];
  wire stat_clr_supp = wr_stat & pwdata[`SSAC_ST_PORT_SUPP];
  wire stat_clr_join = wr_stat & pwdata[`SSAC_ST_JOIN];

  // Sticky flags: hardware set wins over software clear
  wire next_len_err = bad_len | (len_err & ~stat_clr_err);
  wire next_port_supp = port_drop | (port_supp & ~stat_clr_supp);
  wire next_join_seen = join_end | (join_seen & ~stat_clr_join);
  wire [2:0] next_pend = (pend & ~{go_cap, go_port, go_mtu}) |
    ({3{wr_ctrl}} & pwdata[`SSAC_CTRL_SEND_CAP:`SSAC_CTRL_SEND_MTU]);

  wire [31:0] stat_word = {27'h0, join_seen, port_supp, peer_cap, len_err,
    gen_busy | (|pend)};
  wire [31:0] rd_mux =
    sel_ctrl ? {29'h0, pend[2], mcast_sess, udp_en} :
    sel_mtu ? {16'h0, local_mtu_cfg} :
    sel_ports ? {cc_port, sess_port} :
    sel_stat ? stat_word :
    sel_pmtu ? {16'h0, peer_mtu} :
    sel_pport ? {16'h0, peer_port} :
    sel_jsrc ? join_src[127:96] :
    sel_jgrp ? join_grp[127:96] : 32'h0;

  // APB answer: one wait state, then pready for a single cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_wait;
      prdata <= setup_wait & ~pwrite ? rd_mux : 32'h0;
      pslverr <= setup_wait & ~mapped;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      udp_en <= 1'b0;
      mcast_sess <= 1'b0;
      local_mtu_cfg <= `SSAC_RST_MTU;
      sess_port <= `SSAC_RST_PORT;
      cc_port <= `SSAC_RST_PORT;
    end else if (wr) begin
      if (sel_ctrl) begin
        udp_en <= pwdata[`SSAC_CTRL_UDP_EN];
        mcast_sess <= pwdata[`SSAC_CTRL_MCAST];
      end
      // Layer-3 size: IP plus L2TPv3 header and payload
      if (sel_mtu) local_mtu_cfg <= pwdata[15:0];
      if (sel_ports) begin
        sess_port <= pwdata[15:0];
        cc_port <= pwdata[31:16];
      end
    end
  end

  // Send requests and sticky status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 3'h0;
      len_err <= 1'b0;
      port_supp <= 1'b0;
      join_seen <= 1'b0;
    end else begin
      pend <= next_pend;
      len_err <= next_len_err;
      port_supp <= next_port_supp;
      join_seen <= next_join_seen;
    end
  end

  // Emitter launch, one attribute at a time in fixed priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_load <= 1'b0;
      gen_type <= 16'h0;
      gen_value <= 16'h0;
    end else begin
      gen_load <= go_mtu | (go_port & port_ok) | go_cap;
      if (go_mtu) begin
        gen_type <= `SSAC_TYPE_REMOTE_MTU;
        gen_value <= local_mtu_cfg;
      end else if (go_port) begin
        gen_type <= `SSAC_TYPE_UDP_PORT;
        gen_value <= sess_port;
      end else if (go_cap) begin
        gen_type <= `SSAC_TYPE_CAP;
        gen_value <= cap_value;
      end
    end
  end

  ssac_avp_gen u_gen (
    .pclk(pclk),
    .presetn(presetn),
    .load(gen_load),
    .avp_type(gen_type),
    .avp_len(`SSAC_LEN_SHORT),
    .avp_value(gen_value),
    .vendor(VENDOR_ID),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_word(tx_word),
    .tx_last(tx_last),
    .busy(gen_busy)
  );

  // Parser sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= SSAC_RX_HDR;
      hdr_len <= 10'h0;
      idx <= 4'h0;
      joining <= 1'b0;
    end else if (rx_valid) begin
      if (rx_sop) begin
        rx_state <= SSAC_RX_BODY;
        hdr_len <= rx_word[`SSAC_HDR_LEN_MSB:`SSAC_HDR_LEN_LSB];
        idx <= 4'h1;
        joining <= 1'b0;
      end else if (rx_state == SSAC_RX_BODY) begin
        idx <= idx + 4'h1;
        if (type_word) joining <= good & is_join;
        if (join_end) begin
          joining <= 1'b0;
          rx_state <= SSAC_RX_HDR;
        end
      end
    end
  end

  // Parsed values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peer_mtu <= 16'h0;
      peer_port <= 16'h0;
      peer_cap <= 1'b0;
    end else if (good) begin
      if (is_lmtu) peer_mtu <= rx_word[15:0];
      if (is_port) peer_port <= rx_word[15:0];
      if (is_cap) peer_cap <= rx_word[`SSAC_CAP_C_BIT];
    end
  end

  // Join addresses, sixteen bytes each, first word first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      join_src <= 128'h0;
      join_grp <= 128'h0;
      join_valid <= 1'b0;
    end else begin
      join_valid <= join_end;
      if (join_word && idx >= 4'h2 && idx < `SSAC_JOIN_GRP_IDX)
        join_src <= {join_src[95:0], rx_word};
      if (join_word && idx >= `SSAC_JOIN_GRP_IDX)
        join_grp <= {join_grp[95:0], rx_word};
    end
  end

  property p_apb_single;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_apb_single: assert property (p_apb_single)
    else $error("pready held longer than one cycle");

  property p_no_port_mcast;
    @(posedge pclk) disable iff (!presetn)
      gen_load && mcast_sess |-> gen_type != `SSAC_TYPE_UDP_PORT;
  endproperty
  a_no_port_mcast: assert property (p_no_port_mcast)
    else $error("port attribute emitted for multicast session");

  property p_port_needs_udp;
    @(posedge pclk) disable iff (!presetn)
      gen_load && gen_type == `SSAC_TYPE_UDP_PORT |-> udp_en &&
        gen_value != cc_port;
  endproperty
  a_port_needs_udp: assert property (p_port_needs_udp)
    else $error("port attribute without UDP or with same port");

  property p_cap_flag;
    @(posedge pclk) disable iff (!presetn)
      gen_load && gen_type == `SSAC_TYPE_CAP |-> gen_value[`SSAC_CAP_C_BIT];
  endproperty
  a_cap_flag: assert property (p_cap_flag)
    else $error("capability flag not one");

  property p_mtu_value;
    @(posedge pclk) disable iff (!presetn)
      go_mtu |=> gen_load && gen_type == `SSAC_TYPE_REMOTE_MTU &&
        gen_value == $past(local_mtu_cfg);
  endproperty
  a_mtu_value: assert property (p_mtu_value)
    else $error("remote max payload attribute wrong");

  property p_len_err;
    @(posedge pclk) disable iff (!presetn)
      bad_len |=> len_err;
  endproperty
  a_len_err: assert property (p_len_err)
    else $error("length mismatch not flagged");

  property p_join_pulse;
    @(posedge pclk) disable iff (!presetn)
      join_valid |-> $past(joining) && !joining && join_seen;
  endproperty
  a_join_pulse: assert property (p_join_pulse)
    else $error("join pulse without complete join");

  property p_cap_parse;
    @(posedge pclk) disable iff (!presetn)
      good && is_cap |=> peer_cap == $past(rx_word[`SSAC_CAP_C_BIT]);
  endproperty
  a_cap_parse: assert property (p_cap_parse)
    else $error("peer capability not captured");
endmodule : ssac_codec

// [include/ssac_consts.svh]
// Offsets, field positions, codes and reset values for the attribute codec
`ifndef SSAC_CONSTS_SVH
`define SSAC_CONSTS_SVH
`define SSAC_OFF_CTRL 8'h00
`define SSAC_OFF_MTU 8'h04
`define SSAC_OFF_PORTS 8'h08
`define SSAC_OFF_STATUS 8'h0c
`define SSAC_OFF_PEER_MTU 8'h10
`define SSAC_OFF_PEER_PORT 8'h14
`define SSAC_OFF_JOIN_SRC 8'h18
`define SSAC_OFF_JOIN_GRP 8'h1c
`define SSAC_CTRL_UDP_EN 0
`define SSAC_CTRL_MCAST 1
`define SSAC_CTRL_SEND_MTU 8
`define SSAC_CTRL_SEND_PORT 9
`define SSAC_CTRL_SEND_CAP 10
`define SSAC_ST_BUSY 0
`define SSAC_ST_LEN_ERR 1
`define SSAC_ST_PEER_CAP 2
`define SSAC_ST_PORT_SUPP 3
`define SSAC_ST_JOIN 4
`define SSAC_HDR_M_BIT 31
`define SSAC_HDR_H_BIT 30
`define SSAC_HDR_LEN_MSB 25
`define SSAC_HDR_LEN_LSB 16
`define SSAC_CAP_C_BIT 15
`define SSAC_TYPE_LOCAL_MTU 16'h0004
`define SSAC_TYPE_REMOTE_MTU 16'h0007
`define SSAC_TYPE_UDP_PORT 16'h0008
`define SSAC_TYPE_JOIN 16'h000b
`define SSAC_TYPE_CAP 16'h000d
`define SSAC_LEN_SHORT 10'h008
`define SSAC_LEN_JOIN 10'h028
`define SSAC_JOIN_LAST_IDX 4'h9
`define SSAC_JOIN_GRP_IDX 4'h6
`define SSAC_RST_MTU 16'h05dc
`define SSAC_RST_PORT 16'h0000
// Vendor identifier default: arbitrary neutral value
`define SSAC_VENDOR_DEFAULT 16'h0abc
`endif

// [include/ssac_pkg.sv]
// Types shared by the attribute codec modules
package ssac_pkg;
  typedef enum logic [2:0] {
    SSAC_TX_IDLE = 3'b001,
    SSAC_TX_HDR = 3'b010,
    SSAC_TX_VAL = 3'b100
  } ssac_tx_state_t;
  typedef enum logic [1:0] {
    SSAC_RX_HDR = 2'b01,
    SSAC_RX_BODY = 2'b10
  } ssac_rx_state_t;
endpackage : ssac_pkg

// [hw/ssac_avp_gen.sv]
// Two-word attribute emitter with valid/ready handshake
`timescale 1ns/1ps
`include "ssac_consts.svh"
module ssac_avp_gen
  import ssac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [15:0] avp_type,
  input wire logic [9:0] avp_len,
  input wire logic [15:0] avp_value,
  input wire logic [15:0] vendor,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [31:0] tx_word,
  output logic tx_last,
  output logic busy
);
  ssac_tx_state_t state;
  logic [31:0] val_word;
  wire accept = tx_valid & tx_ready;
  // Header packed msb first: M, H, reserved, length, vendor
  wire [31:0] hdr_word = {1'b1, 1'b0, 4'h0, avp_len, vendor};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SSAC_TX_IDLE;
      tx_valid <= 1'b0;
      tx_word <= 32'h0;
      tx_last <= 1'b0;
      val_word <= 32'h0;
    end else begin
      unique case (state)
        SSAC_TX_IDLE: begin
          if (load) begin
            state <= SSAC_TX_HDR;
            tx_valid <= 1'b1;
            tx_word <= hdr_word;
            val_word <= {avp_type, avp_value};
          end
        end
        SSAC_TX_HDR: begin
          if (accept) begin
            state <= SSAC_TX_VAL;
            tx_word <= val_word;
            tx_last <= 1'b1;
          end
        end
        SSAC_TX_VAL: begin
          if (accept) begin
            state <= SSAC_TX_IDLE;
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
          end
        end
      endcase
    end
  end

  assign busy = (state != SSAC_TX_IDLE);

  property p_hdr_mandatory;
    @(posedge pclk) disable iff (!presetn)
      $rose(tx_valid) |-> tx_word[`SSAC_HDR_M_BIT] && !tx_last;
  endproperty
  a_hdr_mandatory: assert property (p_hdr_mandatory)
    else $error("header word lacks mandatory flag");

  property p_hold_until_ready;
    @(posedge pclk) disable iff (!presetn)
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_word);
  endproperty
  a_hold_until_ready: assert property (p_hold_until_ready)
    else $error("word changed before accepted");

  property p_load_starts;
    @(posedge pclk) disable iff (!presetn)
      load && !busy |=> tx_valid && tx_word[9:0] == 10'(vendor[9:0]);
  endproperty
  a_load_starts: assert property (p_load_starts)
    else $error("load did not present header next cycle");
endmodule : ssac_avp_gen

// [bench/ssac_core_model.sv]
// Core-side partner: sends attributes to the codec and accepts its words
`timescale 1ns/1ps
`include "ssac_consts.svh"
module ssac_core_model (
  input wire logic pclk,
  input wire logic slow,
  output logic rx_valid,
  output logic rx_sop,
  output logic [31:0] rx_word,
  output logic tx_ready
);
  logic [1:0] cnt;
  initial begin
    rx_valid = 1'b0;
    rx_sop = 1'b0;
    rx_word = 32'h0;
    tx_ready = 1'b0;
    cnt = 2'h0;
  end
  // Stalls on three cycles of four when slow
  always @(posedge pclk) begin
    cnt <= cnt + 2'h1;
    tx_ready <= !slow || cnt == 2'h0;
  end
  // Header with M set, H clear, vendor code
  function automatic logic [31:0] hdr(input logic [9:0] len);
    return {1'b1, 1'b0, 4'h0, len, `SSAC_VENDOR_DEFAULT};
  endfunction : hdr
  task automatic put(input logic [31:0] w[10], input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_sop <= (i == 0);
      rx_word <= w[i];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_sop <= 1'b0;
    rx_word <= ~w[n-1];
  endtask : put
  // Short attribute: type 4, 8 or 13 with the length given in len
  task automatic avp(input logic [15:0] t, input logic [9:0] len,
                     input logic [15:0] v);
    logic [31:0] w[10];
    w = '{default: 32'h0};
    w[0] = hdr(len);
    w[1] = {t, v};
    put(w, 2);
  endtask : avp
  task automatic send_join(input logic [127:0] src, input logic [127:0] grp);
    logic [31:0] w[10];
    w[0] = hdr(10'h028);
    w[1] = {16'h000b, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      w[2+i] = src[127-32*i -: 32];
      w[6+i] = grp[127-32*i -: 32];
    end
    put(w, 10);
  endtask : send_join
endmodule : ssac_core_model

// [bench/testbench.sv]
// Self-checking bench for the attribute codec
`timescale 1ns/1ps
`include "ssac_consts.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic rx_valid, rx_sop, tx_valid, tx_last, tx_ready, join_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rx_word, tx_word;
  logic [127:0] join_src, join_grp, s, g;
  logic [15:0] v, p;
  int errors, n_compared, seed, cyc;
  logic [32:0] rq[$];
  logic [32:0] tq[$];
  logic [255:0] jq[$];
  ssac_codec dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_sop, .rx_word,
    .tx_valid, .tx_word, .tx_last, .tx_ready, .join_valid, .join_src,
    .join_grp);
  ssac_core_model core (.pclk, .slow, .rx_valid, .rx_sop, .rx_word,
    .tx_ready);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [255:0] got, input logic [255:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic emit(input logic [15:0] t, input logic [15:0] val);
    tq.push_back({1'b0, 1'b1, 1'b0, 4'h0, 10'h008, `SSAC_VENDOR_DEFAULT});
    tq.push_back({1'b1, t, val});
  endtask : emit
  task automatic drain;
    int k;
    k = 0;
    while ((tq.size() + jq.size()) != 0 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    chk(tq.size() + jq.size(), 0, "results missing");
  endtask : drain
  // Monitor: each result takes the oldest note
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[FAIL] %0t run too long", $time);
      print_verdict();
    end
    if (psel && penable && pready && !pwrite) begin
      if (rq.size() == 0) chk(1, 0, "stray read");
      else chk({pslverr, prdata}, rq.pop_front(), "read");
    end
    if (tx_valid && tx_ready) begin
      if (tq.size() == 0) chk(1, 0, "stray word");
      else chk({tx_last, tx_word}, tq.pop_front(), "tx word");
    end
    if (join_valid) begin
      if (jq.size() == 0) chk(1, 0, "stray join");
      else chk({join_src, join_grp}, jq.pop_front(), "join");
    end
  end
  initial begin
    seed = 33613;
    {psel, penable, pwrite, slow, presetn} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 33'h0);
    rd(8'h04, {17'h0, `SSAC_RST_MTU});
    rd(8'h08, 33'h0);
    rd(8'h0c, 33'h0);
    apb(1'b1, 8'h24, 32'hffff_ffff);
    rd(8'h24, {1'b1, 32'h0});
    $display("test reset done");
    slow <= 1'b1;
    v = 16'($random(seed));
    apb(1'b1, 8'h04, {16'h0, v});
    emit(`SSAC_TYPE_REMOTE_MTU, v);
    apb(1'b1, 8'h00, 32'h100);
    emit(`SSAC_TYPE_CAP, 16'h8000);
    apb(1'b1, 8'h00, 32'h400);
    drain();
    $display("test emit done");
    p = 16'($random(seed));
    apb(1'b1, 8'h08, {p ^ 16'h0001, p});
    emit(`SSAC_TYPE_UDP_PORT, p);
    apb(1'b1, 8'h00, 32'h201);
    drain();
    apb(1'b1, 8'h00, 32'h203);
    rd(8'h00, 33'h3);
    rd(8'h0c, 33'h8);
    apb(1'b1, 8'h0c, 32'h8);
    apb(1'b1, 8'h00, 32'h200);
    rd(8'h0c, 33'h8);
    apb(1'b1, 8'h0c, 32'h8);
    apb(1'b1, 8'h08, {p, p});
    apb(1'b1, 8'h00, 32'h201);
    rd(8'h0c, 33'h8);
    apb(1'b1, 8'h0c, 32'h8);
    rd(8'h0c, 33'h0);
    $display("test port done");
    core.avp(`SSAC_TYPE_LOCAL_MTU, 10'h008, v);
    rd(8'h10, {17'h0, v});
    core.avp(`SSAC_TYPE_UDP_PORT, 10'h008, p);
    rd(8'h14, {17'h0, p});
    core.avp(`SSAC_TYPE_CAP, 10'h008, 16'h8000);
    rd(8'h0c, 33'h4);
    core.avp(`SSAC_TYPE_LOCAL_MTU, 10'h00c, ~v);
    rd(8'h0c, 33'h6);
    rd(8'h10, {17'h0, v});
    $display("test parse done");
    for (int k = 0; k < 2; k++) begin
      s = {$random(seed), $random(seed), $random(seed), $random(seed)};
      g = {$random(seed), $random(seed), $random(seed), $random(seed)};
      if (k == 0) begin
        s[95:0] = 96'h0;
        g[95:0] = 96'h0;
      end
      jq.push_back({s, g});
      core.send_join(s, g);
      drain();
      rd(8'h18, {1'b0, s[127:96]});
      rd(8'h1c, {1'b0, g[127:96]});
    end
    rd(8'h0c, 33'h16);
    $display("test join done");
    print_verdict();
  end
endmodule : testbench
